// ===== hdl/cdus_pkg.sv
package cdus_pkg;
  // ****************************************************************
  // Register map (word aligned byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_HIGH0  = 4'h4;
  localparam logic [3:0] ADDR_LOW0   = 4'h8;
  localparam logic [3:0] ADDR_CTRL1  = 4'hc;
  localparam logic [3:0] ADDR_HIGH1  = 4'h0;
  localparam int         NUM_CONV    = 2;
  localparam int         WORD_W      = 12;
  // Channel n register block spacing and base
  localparam logic [4:0] CH_STRIDE   = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int         EN_BIT      = 7;
  localparam int         SRC_HI      = 6;
  localparam int         SRC_LO      = 4;
  localparam int         RJST_BIT    = 2;
  localparam int         FS_HI       = 1;
  localparam logic [7:0] CTRL_RESET  = 8'h73;
  localparam logic [7:0] CTRL_WMASK  = 8'hf7;
  // Update sources
  localparam logic [2:0] SRC_TMR0    = 3'h0;
  localparam logic [2:0] SRC_TMR1    = 3'h1;
  localparam logic [2:0] SRC_TMR2    = 3'h2;
  localparam logic [2:0] SRC_TMR3    = 3'h3;
  localparam logic [2:0] SRC_RISE    = 3'h4;
  localparam logic [2:0] SRC_FALL    = 3'h5;
  localparam logic [2:0] SRC_BOTH    = 3'h6;
  localparam logic [2:0] SRC_WRITE   = 3'h7;
  // Full scale codes: 0.25, 0.5, 1, 2 mA
  localparam logic [1:0] FS_0P25MA   = 2'h0;
  localparam logic [1:0] FS_0P5MA    = 2'h1;
  localparam logic [1:0] FS_1MA      = 2'h2;
  localparam logic [1:0] FS_2MA      = 2'h3;
endpackage

// ===== hdl/cdus_top.sv
// Function
// [R1] Each converter has its own enable bit; one never disturbs the other.
// [R2] Two-bit full-scale select gives 0.25, 0.5, 1 or 2 mA.
// [R3] Source 111 (reset default): high-byte write loads whole word into latch.
// [R4] In on-demand mode a low-byte write is only stored, latch unchanged.
// [R5] Software writes low byte first, high byte last, in on-demand mode.
// [R6] For 8-bit left-justified use, preload low byte then write high only.
// [R7] Sources 000..011: latch loads only on timer 0..3 overflow.
// [R8] Timers 2/3: low-byte overflow in 8-bit mode, high-byte in 16-bit.
// [R9] Sources 100/101/110: latch loads on strobe rise, fall, or either edge.
// [R10] Left: D11-4 high[7:0], D3-0 low[7:4]; right: D11-8 high[3:0], D7-0 low.
// [R11] Justify select at control bit 2; full scale resets to 2 mA.
// [R12] Latch holds its value between update events.
// [R13] Data byte reads return last written value, latched or not.
`timescale 1ns/1ps
`default_nettype none
module cdus_top (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic [5:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  input  wire logic [3:0]  i_timer_overflow,
  input  wire logic [1:0]  i_timer_high_overflow,
  input  wire logic [1:0]  i_timer_16bit_mode,
  input  wire logic        i_external_convert_strobe,
  output logic      [11:0] o_latch0,
  output logic      [11:0] o_latch1,
  output logic      [1:0]  o_enable,
  output logic      [3:0]  o_full_scale_select
);
  // ****************************************************************
  // Register offsets inside one channel block
  // ****************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_HIGH = 4'h4;
  localparam logic [3:0] OFS_LOW  = 4'h8;
  localparam logic [3:0] OFS_LTCH = 4'hc;

  // ****************************************************************
  // Strobe pin synchroniser and edge detect
  // ****************************************************************
  logic strobe_meta, strobe_sync, strobe_prev;
  logic next_strobe_meta, next_strobe_sync, next_strobe_prev;
  logic strobe_rise, strobe_fall;

  // Two flops before any logic looks at the pin
  always_comb begin
    next_strobe_meta = i_external_convert_strobe;
    next_strobe_sync = strobe_meta;
    next_strobe_prev = strobe_sync;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      strobe_meta <= next_strobe_meta;
      strobe_sync <= next_strobe_sync;
      strobe_prev <= next_strobe_prev;
    end
  end

  assign strobe_rise = strobe_sync & ~strobe_prev;
  assign strobe_fall = ~strobe_sync & strobe_prev;

  // ****************************************************************
  // Timer overflow selection for timers 2 and 3
  // ****************************************************************
  logic [3:0] tmr_event;

  // Width of the counting stage decides which overflow counts
  always_comb begin
    tmr_event[0] = i_timer_overflow[0];
    tmr_event[1] = i_timer_overflow[1];
    tmr_event[2] = i_timer_16bit_mode[0] ? i_timer_high_overflow[0]
                                         : i_timer_overflow[2]; // [R8]
    tmr_event[3] = i_timer_16bit_mode[1] ? i_timer_high_overflow[1]
                                         : i_timer_overflow[3]; // [R8]
  end

  // ****************************************************************
  // Bus access decode; one wait cycle so read data is registered
  // ****************************************************************
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic        bus_req;
  logic        wr_take;
  logic        ch_sel;
  logic [3:0]  ofs;

  assign bus_req = (i_read | i_write) & ~ack;
  assign wr_take = i_write & bus_req;
  assign ch_sel  = i_address[4];
  assign ofs     = i_address[3:0];

  // ****************************************************************
  // Per converter registers
  // ****************************************************************
  logic [7:0]  ctrl   [cdus_pkg::NUM_CONV];
  logic [7:0]  hbyte  [cdus_pkg::NUM_CONV];
  logic [7:0]  lbyte  [cdus_pkg::NUM_CONV];
  logic [11:0] latch  [cdus_pkg::NUM_CONV];

  genvar g;
  generate
    for (g = 0; g < cdus_pkg::NUM_CONV; g = g + 1) begin : g_conv
      logic [7:0]  next_ctrl, next_hbyte, next_lbyte;
      logic [11:0] next_latch;
      logic [11:0] word;
      logic        sel, hi_wr, upd;
      logic [2:0]  src;

      assign sel   = wr_take & (ch_sel == 1'(g)) & ~i_address[5];
      assign hi_wr = sel & (ofs == OFS_HIGH);
      assign src   = ctrl[g][cdus_pkg::SRC_HI:cdus_pkg::SRC_LO];

      // Assemble the 12-bit word from the stored bytes
      always_comb begin
        if (ctrl[g][cdus_pkg::RJST_BIT]) begin
          word = {hbyte[g][3:0], lbyte[g]}; // [R10]
        end else begin
          word = {hbyte[g], lbyte[g][7:4]}; // [R10]
        end
      end

      // Update event chosen by the source field
      always_comb begin
        case (src)
          cdus_pkg::SRC_TMR0:  upd = tmr_event[0]; // [R7]
          cdus_pkg::SRC_TMR1:  upd = tmr_event[1]; // [R7]
          cdus_pkg::SRC_TMR2:  upd = tmr_event[2]; // [R7]
          cdus_pkg::SRC_TMR3:  upd = tmr_event[3]; // [R7]
          cdus_pkg::SRC_RISE:  upd = strobe_rise; // [R9]
          cdus_pkg::SRC_FALL:  upd = strobe_fall; // [R9]
          cdus_pkg::SRC_BOTH:  upd = strobe_rise | strobe_fall; // [R9]
          default:             upd = 1'b0;
        endcase
      end

      // Register writes and latch transfer
      always_comb begin
        next_ctrl  = ctrl[g];
        next_hbyte = hbyte[g];
        next_lbyte = lbyte[g];
        next_latch = latch[g]; // [R12]
        if (sel && ofs == OFS_CTRL) begin
          next_ctrl = i_writedata[7:0] & cdus_pkg::CTRL_WMASK; // [R1]
        end
        if (hi_wr) begin
          next_hbyte = i_writedata[7:0]; // [R13]
        end
        if (sel && ofs == OFS_LOW) begin
          next_lbyte = i_writedata[7:0]; // [R4]
        end
        if (src == cdus_pkg::SRC_WRITE) begin
          // High write takes fresh high byte plus held low byte
          if (hi_wr) begin
            if (ctrl[g][cdus_pkg::RJST_BIT]) begin
              next_latch = {i_writedata[3:0], lbyte[g]}; // [R3]
            end else begin
              next_latch = {i_writedata[7:0], lbyte[g][7:4]}; // [R3]
            end
          end
        end else if (upd) begin
          next_latch = word; // [R7]
        end
      end

      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          ctrl[g]  <= cdus_pkg::CTRL_RESET; // [R11]
          hbyte[g] <= 8'h00;
          lbyte[g] <= 8'h00;
          latch[g] <= 12'h000;
        end else begin
          ctrl[g]  <= next_ctrl;
          hbyte[g] <= next_hbyte;
          lbyte[g] <= next_lbyte;
          latch[g] <= next_latch;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read mux and wait handshake
  // ****************************************************************
  // Reads of unmapped offsets return zero
  always_comb begin
    next_ack      = bus_req;
    next_readdata = 32'h0000_0000;
    if (i_read && bus_req && !i_address[5]) begin
      case (ofs)
        OFS_CTRL: next_readdata = {24'h00_0000, ctrl[ch_sel]}; // [R11]
        OFS_HIGH: next_readdata = {24'h00_0000, hbyte[ch_sel]}; // [R13]
        OFS_LOW:  next_readdata = {24'h00_0000, lbyte[ch_sel]}; // [R13]
        OFS_LTCH: next_readdata = {20'h0_0000, latch[ch_sel]};
        default:  next_readdata = 32'h0000_0000;
      endcase
    end else if (!bus_req) begin
      next_readdata = o_readdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ack        <= 1'b0;
      o_readdata <= 32'h0000_0000;
    end else begin
      ack        <= next_ack;
      o_readdata <= next_readdata;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic [1:0] next_enable;
  logic [3:0] next_fs;
  logic       next_wait;

  // Each converter's enable and full scale drawn from its own control
  always_comb begin
    next_enable = {ctrl[1][cdus_pkg::EN_BIT], ctrl[0][cdus_pkg::EN_BIT]}; // [R1]
    next_fs     = {ctrl[1][cdus_pkg::FS_HI:0], ctrl[0][cdus_pkg::FS_HI:0]}; // [R2]
    next_wait   = ~bus_req;
  end

  // Waitrequest idles high; drops for one cycle to answer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_enable            <= 2'h0;
      o_full_scale_select <= {cdus_pkg::FS_2MA, cdus_pkg::FS_2MA}; // [R11]
      o_waitrequest       <= 1'b1;
      o_latch0            <= 12'h000;
      o_latch1            <= 12'h000;
    end else begin
      o_enable            <= next_enable;
      o_full_scale_select <= next_fs;
      o_waitrequest       <= next_wait;
      o_latch0            <= latch[0];
      o_latch1            <= latch[1];
    end
  end
endmodule // cdus_top
`default_nettype wire

// ===== tb/cdus_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cdus_properties (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic [5:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic [3:0]  i_timer_overflow,
  input wire logic [1:0]  i_timer_high_overflow,
  input wire logic        i_external_convert_strobe,
  input wire logic [11:0] o_latch0,
  input wire logic [11:0] o_latch1,
  input wire logic [1:0]  o_enable,
  input wire logic [3:0]  o_full_scale_select
);
  // ****************************************************************
  // Port checks
  // ****************************************************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic       acc_w;
  logic       hi_seen;
  logic [7:0] hi_shadow;
  logic [2:0] quiet;
  assign acc_w = i_write && !o_waitrequest;
  // Shadow of high byte; quiet counts cycles with no possible update cause
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_seen   <= 1'b0;
      hi_shadow <= 8'h00;
      quiet     <= 3'h0;
    end else begin
      if (acc_w && i_address == 6'h04) begin
        hi_seen   <= 1'b1;
        hi_shadow <= i_writedata[7:0];
      end
      quiet <= (i_write || |i_timer_overflow || |i_timer_high_overflow ||
                $changed(i_external_convert_strobe)) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  a_wait_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_reset_values: assert property (!$past(i_resetn) |-> o_full_scale_select == 4'hf &&
    o_enable == 2'h0 && o_latch0 == 12'h0) else $error("wrong values after reset");
  a_enable_follows: assert property (acc_w && i_address == 6'h00 |=>
    o_enable[0] == $past(i_writedata[7]) && $stable(o_enable[1])) else $error("enable bad");
  a_scale_follows: assert property (acc_w && i_address == 6'h00 |=>
    o_full_scale_select[1:0] == $past(i_writedata[1:0]) && $stable(o_full_scale_select[3:2]))
    else $error("full scale bad");
  a_ctrl_read: assert property (i_read && !o_waitrequest && i_address == 6'h00 |->
    o_readdata[31:8] == 24'h0 && !o_readdata[3]) else $error("control read bad");
  a_high_read: assert property (i_read && !o_waitrequest && i_address == 6'h04 && hi_seen
    |-> o_readdata[7:0] == hi_shadow) else $error("high byte read bad");
  a_latch_quiet: assert property (quiet >= 3'h6 |-> $stable(o_latch0) && $stable(o_latch1))
    else $error("latch moved without cause");
  c_high_write: cover property (acc_w && i_address == 6'h04);
  c_high_ovf: cover property (|i_timer_high_overflow);
  c_strobe_rise: cover property ($rose(i_external_convert_strobe));
endmodule // cdus_properties
bind cdus_top cdus_properties chk (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_timer_overflow(i_timer_overflow),
  .i_timer_high_overflow(i_timer_high_overflow), .o_latch0(o_latch0), .o_latch1(o_latch1),
  .i_external_convert_strobe(i_external_convert_strobe), .o_enable(o_enable),
  .o_full_scale_select(o_full_scale_select));
`default_nettype wire

// ===== tb/cdus_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdus_timer_model (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic [5:0] i_fire,
  output logic      [3:0] o_overflow,
  output logic      [1:0] o_high_overflow
);
  // ****************************************************************
  // Timer overflow pulses, one cycle each, quiet in reset
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_overflow      <= 4'h0;
      o_high_overflow <= 2'h0;
    end else begin
      o_overflow      <= i_fire[3:0];
      o_high_overflow <= i_fire[5:4];
    end
  end
endmodule // cdus_timer_model
`default_nettype wire

// ===== tb/test_current_dac_update_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
module test_current_dac_update_scheduler;
  // ****************************************************************
  // Stimulus and checking
  // ****************************************************************
  typedef struct packed {
    logic ch; logic [7:0] ctrl, lo, hi; logic [5:0] fire; logic [1:0] mode; logic stb;
    logic [11:0] lat; logic [1:0] en; logic [3:0] fs;
  } cdus_row_t;
  logic        i_clock = 1'b0, i_resetn = 1'b0, i_read = 1'b0, i_write = 1'b0, stb = 1'b0;
  logic [5:0]  addr = 6'h00, fire = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  mode = 2'h0, en, hov;
  logic [3:0]  tov, fs;
  logic        wreq;
  logic [11:0] lat0, lat1;
  int          n_fail = 0, total_checks = 0, cycles = 0;
  // Register rows first, then timer and strobe sources on converter 0
  cdus_row_t rows [18] = '{
    '{0, 8'hf0, 8'ha0, 8'h5c, 0, 0, 0, 12'h5ca, 1, 4'hc}, '{0, 8'hf5, 8'h34, 8'h0b, 0, 0, 0, 12'hb34, 1, 4'hd},
    '{1, 8'hf6, 8'h00, 8'hff, 0, 0, 0, 12'hf00, 3, 4'h9}, '{1, 8'h77, 8'h12, 8'hf3, 0, 0, 0, 12'h312, 1, 4'hd},
    '{0, 8'h80, 0, 8'h10, 6'h02, 0, 0, 12'hb34, 1, 4'hc}, '{0, 8'h80, 0, 8'h10, 6'h01, 0, 0, 12'h100, 1, 4'hc},
    '{0, 8'h90, 0, 8'h11, 6'h01, 0, 0, 12'h100, 1, 4'hc}, '{0, 8'h90, 0, 8'h11, 6'h02, 0, 0, 12'h110, 1, 4'hc},
    '{0, 8'ha0, 0, 8'h12, 6'h04, 0, 0, 12'h120, 1, 4'hc}, '{0, 8'hb0, 0, 8'h13, 6'h08, 0, 0, 12'h130, 1, 4'hc},
    '{0, 8'ha0, 0, 8'h22, 6'h04, 3, 0, 12'h130, 1, 4'hc}, '{0, 8'ha0, 0, 8'h22, 6'h10, 3, 0, 12'h220, 1, 4'hc},
    '{0, 8'hb0, 0, 8'h23, 6'h20, 3, 0, 12'h230, 1, 4'hc}, '{0, 8'hd0, 0, 8'h31, 0, 0, 1, 12'h230, 1, 4'hc},
    '{0, 8'hd0, 0, 8'h31, 0, 0, 0, 12'h310, 1, 4'hc}, '{0, 8'hc0, 0, 8'h41, 0, 0, 1, 12'h410, 1, 4'hc},
    '{0, 8'he0, 0, 8'h51, 0, 0, 0, 12'h510, 1, 4'hc}, '{0, 8'he0, 0, 8'h52, 0, 0, 1, 12'h520, 1, 4'hc}};
  cdus_top dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_address(addr), .i_read(i_read),
    .i_write(i_write), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(wreq),
    .i_timer_overflow(tov), .i_timer_high_overflow(hov), .i_timer_16bit_mode(mode),
    .i_external_convert_strobe(stb), .o_latch0(lat0), .o_latch1(lat1), .o_enable(en),
    .o_full_scale_select(fs));
  cdus_timer_model tmr (.i_clock(i_clock), .i_resetn(i_resetn), .i_fire(fire),
    .o_overflow(tov), .o_high_overflow(hov));
  always #10 i_clock = ~i_clock;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Avalon access: hold everything until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= {24'h0, d};
    i_write <= w;
    i_read <= !w;
    // Sample waitrequest and read data at the rising edge itself
    do @(posedge i_clock); while (wreq !== 1'b0);
    rd = rdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    chk("reset scale", 32'hf, {28'h0, fs});
    i_resetn <= 1'b1;
    bus(0, 6'h00, 8'h00);
    chk("ctrl0 reset", 32'h73, rd);
    foreach (rows[i]) begin
      bus(1, {1'b0, rows[i].ch, 4'h0}, rows[i].ctrl);
      bus(1, {1'b0, rows[i].ch, 4'h8}, rows[i].lo);
      bus(1, {1'b0, rows[i].ch, 4'h4}, rows[i].hi);
      @(posedge i_clock);
      fire <= rows[i].fire;
      mode <= rows[i].mode;
      stb <= rows[i].stb;
      @(posedge i_clock);
      fire <= 6'h00;
      repeat (6) @(posedge i_clock);
      chk("latch", rows[i].lat, rows[i].ch ? lat1 : lat0);
      chk("enable", rows[i].en, en);
      chk("scale", rows[i].fs, fs);
    end
    bus(1, 6'h00, 8'hf0);
    bus(1, 6'h08, 8'h70);
    repeat (6) @(posedge i_clock);
    chk("low held", 12'h520, lat0);
    bus(0, 6'h08, 8'h00);
    chk("low read", 32'h70, rd);
    bus(0, 6'h04, 8'h00);
    chk("high read", 32'h52, rd);
    bus(1, 6'h0c, 8'hff);
    bus(0, 6'h0c, 8'h00);
    chk("latch read", 32'h520, rd);
    bus(0, 6'h24, 8'h00);
    chk("unmapped", 32'h0, rd);
    // Second reset in mid-run
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk("reset out", 32'hf, {lat1, lat0, en, fs});
    i_resetn <= 1'b1;
    bus(0, 6'h10, 8'h00);
    chk("ctrl1 reset", 32'h73, rd);
    end_of_test();
  end
endmodule // test_current_dac_update_scheduler
`default_nettype wire
